// *** dv/mpfc_engine_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// engine position tracker and key source
// ----------------------------------------
module mpfc_engine_model #(
  parameter int unsigned DIV = 4,
  parameter int unsigned CYC = 64,
  parameter logic [31:0] KEY = 32'h5A5AC3C3 // arbitrary value
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  run,
  input  wire logic                  key_on,
  output mpfc_pkg::mpfc_epos_s       epos,
  output logic [31:0]                key_q
);
  import mpfc_pkg::*;
  logic [7:0] div;
  // angle steps once every DIV clocks while running, wraps at CYC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 8'h00;
      epos <= '0;
    end else begin
      epos.synced <= 1'b1;
      epos.cycle_len <= CYC[15:0];
      if (run) begin
        div <= (div == 8'(DIV - 1)) ? 8'h00 : div + 8'h01;
        if (div == 8'(DIV - 1)) begin
          epos.angle <= (epos.angle == 16'(CYC - 1)) ? 16'h0000 : epos.angle + 16'h0001;
        end
      end
    end
  end
  // supervisor key through a single register stage, inverted when absent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) key_q <= 32'h00000000;
    else key_q <= key_on ? KEY : ~KEY;
  end
endmodule

// *** dv/multipulse_fuel_command_mux4_tb.sv ***
`timescale 1ns/1ps
module multipulse_fuel_command_mux4_tb;
  import mpfc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, key_on = 0, cnt_en = 0, sw_d = 0;
  logic p1_d = 0;
  int pr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, key;
  logic pready, pslverr, channel_switch_strobe, pulse_train_ch1, pulse_train_ch2, pulse_train_ch3, pulse_train_ch4;
  mpfc_epos_s epos;
  int err_count = 0, cmp_count = 0, seed = 81, sw_n, sw_r;
  int hi[4];
  always #10 pclk = ~pclk;
  mpfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .engine_position_bundle(epos), .unlock_key(key), .channel_switch_strobe(channel_switch_strobe),
    .pulse_train_ch1(pulse_train_ch1), .pulse_train_ch2(pulse_train_ch2),
    .pulse_train_ch3(pulse_train_ch3), .pulse_train_ch4(pulse_train_ch4));
  mpfc_engine_model ENG (.pclk(pclk), .presetn(presetn), .run(run), .key_on(key_on), .epos(epos), .key_q(key));
  // count high cycles per output and strobe cycles and rises
  always @(posedge pclk) begin
    sw_d <= channel_switch_strobe;
    p1_d <= pulse_train_ch1;
    if (cnt_en) begin
      pr += (pulse_train_ch1 && !p1_d);
      hi[0] += pulse_train_ch1;
      hi[1] += pulse_train_ch2;
      hi[2] += pulse_train_ch3;
      hi[3] += pulse_train_ch4;
      sw_n += channel_switch_strobe;
      sw_r += (channel_switch_strobe && !sw_d);
    end
  end
  task test_done;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      test_done;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  // expected high clocks: lengths in 40 MHz ticks seen at 50 MHz
  function automatic int exp_hi(input logic [4:0] c, input int l, output int np);
    int s;
    s = 0;
    np = 0;
    if (c[0] && key_on) begin
      s = l + (c[1] ? 4 : 0) + (c[2] ? 4 : 0) + (c[3] ? 6 : 0) + ((c[3] && c[4]) ? 5 : 0);
      np = 1 + c[1] + c[2] + c[3] + (c[3] & c[4]);
    end
    return s * 5 / 4;
  endfunction
  // run one engine cycle and compare pulse and strobe counts
  task automatic pass(input logic [4:0] c, input int l, input int sw);
    int e, np;
    e = exp_hi(c, l, np);
    foreach (hi[i]) hi[i] = 0;
    sw_n = 0;
    sw_r = 0;
    pr = 0;
    @(posedge pclk);
    cnt_en <= 1'b1;
    run <= 1'b1;
    repeat (256) @(posedge pclk);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    cnt_en <= 1'b0;
    @(posedge pclk);
    chk(hi[0] >= e - 2 * np && hi[0] <= e + 2 * np, "pulse train length");
    chk(hi[1] + hi[2] + hi[3] == 0, "inactive channel pulsed");
    chk(pr == np, "pulse count");
    if (sw >= 0) chk(sw_n == sw && sw_r == sw, "switch strobe count");
  endtask
  initial begin
    #400000;
    err_count++;
    test_done;
  end
  initial begin
    int i, k, l;
    logic [31:0] r;
    logic e;
    logic [4:0] c;
    static logic [11:0] wa[7] = '{12'h010, 12'h014, 12'h018, 12'h020, 12'h028, 12'h01C, 12'h024};
    static logic [11:0] ca[9] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h01C, 12'h020, 12'h024, 12'h028};
    static logic [31:0] cd[9] = '{8, 6, 3, 4, 4, 32'h01000004, 6, 3, 5};
    static int swa[4] = '{40, 48, 56, 1};
    static logic [4:0] codes[8] = '{5'h1E, 5'h01, 5'h03, 5'h05, 5'h09, 5'h11, 5'h19, 5'h1F};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pulse_train_ch1, pulse_train_ch2, pulse_train_ch3, pulse_train_ch4} === 4'h0, "outputs after reset");
    for (i = 0; i < 7; i++) begin
      wr(wa[i], 32'hFFFFFFFF);
      apb(1'b0, wa[i], 32'h00000000, r, e);
      chk(r === ((i < 5) ? 32'h0003FFFF : 32'h00FFFFFF), "field width");
    end
    apb(1'b1, 12'h300, 32'hFFFFFFFF, r, e);
    chk(e === 1'b1, "unmapped write");
    apb(1'b0, 12'h300, 32'h00000000, r, e);
    chk(e === 1'b1 && r === 32'h00000000, "unmapped read");
    for (i = 0; i < 9; i++) wr(ca[i], cd[i]);
    for (i = 0; i < 4; i++) wr(12'h02C + 12'(i) * 12'h040, 32'(swa[i]));
    wr(12'h018, 32'h00000014);
    wr(12'h000, 32'h0000001F);
    pass(5'h1F, 20, -1);
    key_on <= 1'b1;
    repeat (4) @(posedge pclk);
    // status: channel 3 active and idle after a full cycle, now unlocked
    apb(1'b0, 12'h100, 32'h00000000, r, e);
    chk(r === 32'h0000001B && e === 1'b0, "status after unlock");
    for (k = 0; k < 12; k++) begin
      l = 8 + ($unsigned($random(seed)) % 32);
      c = (k < 8) ? codes[k] : 5'($random(seed));
      wr(12'h018, 32'h00040000 + 32'(l));
      wr(12'h000, {27'h0, c});
      pass(c, l, 4);
    end
    test_done;
  end
endmodule

// *** hw/mpfc_defines.svh ***
`ifndef MPFC_DEFINES_SVH
`define MPFC_DEFINES_SVH

// ----------------------------------------
// clock and tick rates
// ----------------------------------------
`define MPFC_PCLK_MHZ     7'd50
`define MPFC_TICK_MHZ     7'd40

// ----------------------------------------
// field widths
// ----------------------------------------
`define MPFC_LEN_W        18
`define MPFC_GAP_W        24
`define MPFC_ANG_W        16
`define MPFC_KEY_W        32

// ----------------------------------------
// register map: per-channel block, stride 0x40, plus one shared status register at 0x100
// ----------------------------------------
`define MPFC_CH_STRIDE    12'h040
`define MPFC_OFF_CTRL     6'h00
`define MPFC_OFF_START    6'h04
`define MPFC_OFF_ADV1     6'h08
`define MPFC_OFF_ADV2     6'h0C
`define MPFC_OFF_LEN1     6'h10
`define MPFC_OFF_LEN2     6'h14
`define MPFC_OFF_LENP     6'h18
`define MPFC_OFF_GAP1     6'h1C
`define MPFC_OFF_LEN3     6'h20
`define MPFC_OFF_GAP2     6'h24
`define MPFC_OFF_LEN4     6'h28
`define MPFC_OFF_SWITCH   6'h2C
`define MPFC_OFF_STATUS   12'h100

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define MPFC_BIT_GATE     0
`define MPFC_BIT_E1       1
`define MPFC_BIT_E2       2
`define MPFC_BIT_L1       3
`define MPFC_BIT_L2       4

`endif

// *** hw/mpfc_pkg.sv ***
`include "mpfc_defines.svh"

package mpfc_pkg;

  // engine position as delivered by the tracker
  typedef struct packed {
    logic                    synced;
    logic [`MPFC_ANG_W-1:0]  cycle_len;
    logic [`MPFC_ANG_W-1:0]  angle;
  } mpfc_epos_s;

  // one channel's pulse settings
  typedef struct packed {
    logic                    gate;
    logic                    e1_on;
    logic                    e2_on;
    logic                    l1_on;
    logic                    l2_on;
    logic [`MPFC_ANG_W-1:0]  start;
    logic [`MPFC_ANG_W-1:0]  adv1;
    logic [`MPFC_ANG_W-1:0]  adv2;
    logic [`MPFC_LEN_W-1:0]  len1;
    logic [`MPFC_LEN_W-1:0]  len2;
    logic [`MPFC_LEN_W-1:0]  lenp;
    logic [`MPFC_GAP_W-1:0]  gap1;
    logic [`MPFC_LEN_W-1:0]  len3;
    logic [`MPFC_GAP_W-1:0]  gap2;
    logic [`MPFC_LEN_W-1:0]  len4;
    logic [`MPFC_ANG_W-1:0]  sw_angle;
  } mpfc_chan_s;

  // sequence of the primary and late pulses
  typedef enum logic [6:0] {
    MPFC_IDLE  = 7'b0000001,
    MPFC_PRIM  = 7'b0000010,
    MPFC_GAP1  = 7'b0000100,
    MPFC_LATE1 = 7'b0001000,
    MPFC_GAP2  = 7'b0010000,
    MPFC_LATE2 = 7'b0100000,
    MPFC_DONE  = 7'b1000000
  } mpfc_seq_e;

  typedef logic [1:0] mpfc_ch_t;

endpackage

// *** hw/mpfc_top.sv ***
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mpfc_defines.svh"

// Behaviour
// - primary gate off blocks all five pulses of a channel
// - first early pulse only while its enable is set
// - second early pulse only while its enable is set
// - first late pulse only while its enable is set
// - second late pulse needs its own and the first late enable
// - primary pulse rises at start angle, lasts programmed length
// - first early pulse starts programmed angle ticks before start angle
// - second early pulse starts programmed angle ticks before start angle
// - first early length in 40 MHz ticks, low 18 bits only
// - second early length in 40 MHz ticks, low 18 bits only
// - primary length in 40 MHz ticks, low 18 bits only
// - first late starts programmed gap after primary ends, 24-bit ticks
// - first late length in 40 MHz ticks, low 18 bits only
// - second late starts programmed gap after first late ends, 24 bits
// - second late length in 40 MHz ticks, low 18 bits only
// - one pulse engine serves four channels, advancing at switch angle
// - switch strobe lasts exactly one clock at each switch angle
// - unlock key passes one register stage; pulse train outputs locked without it, switch strobe runs regardless
// - four separate pulse train outputs, one per channel
// - at most five pulses per channel per engine cycle
// - every step completes in one clock
module mpfc_top #(
  parameter logic [`MPFC_KEY_W-1:0] UNLOCK_KEY = 32'h5A5A_C3C3 // arbitrary value
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire mpfc_pkg::mpfc_epos_s    engine_position_bundle,
  input  wire logic [`MPFC_KEY_W-1:0]  unlock_key,
  output logic                         channel_switch_strobe,
  output logic                         pulse_train_ch1,
  output logic                         pulse_train_ch2,
  output logic                         pulse_train_ch3,
  output logic                         pulse_train_ch4
);
  import mpfc_pkg::*;

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // position a number of angle ticks before a reference, wrapped in the cycle
  function automatic logic [`MPFC_ANG_W-1:0] ang_before(input logic [`MPFC_ANG_W-1:0] ref_a,
                                                         input logic [`MPFC_ANG_W-1:0] adv,
                                                         input logic [`MPFC_ANG_W-1:0] clen);
    if (ref_a >= adv) begin
      ang_before = ref_a - adv;
    end else begin
      ang_before = ref_a + clen - adv;
    end
  endfunction

  // one tick of a length down-counter
  function automatic logic [`MPFC_LEN_W-1:0] len_step(input logic [`MPFC_LEN_W-1:0] cnt,
                                                       input logic                   tk);
    len_step = (tk && cnt != '0) ? cnt - 1'b1 : cnt;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  mpfc_chan_s               cfg [4];
  mpfc_ch_t                 cur_ch;
  mpfc_seq_e                seq;
  logic [6:0]               tick_acc;
  logic                     tick;
  logic [`MPFC_KEY_W-1:0]   key_q;
  logic                     unlocked;
  logic [`MPFC_ANG_W-1:0]   prev_angle;
  logic [`MPFC_LEN_W-1:0]   cnt_e1;
  logic [`MPFC_LEN_W-1:0]   cnt_e2;
  logic [`MPFC_LEN_W-1:0]   cnt_p;
  logic [`MPFC_LEN_W-1:0]   cnt_l1;
  logic [`MPFC_LEN_W-1:0]   cnt_l2;
  logic [`MPFC_GAP_W-1:0]   cnt_gap;
  mpfc_chan_s               cc;
  logic                     new_pos;
  logic                     hit_e1;
  logic                     hit_e2;
  logic                     hit_p;
  logic                     hit_sw;
  logic                     any_pulse;
  logic                     wr_en;
  logic                     rd_en;
  logic [1:0]               rch;
  logic [5:0]               roff;
  logic                     rmapped;
  logic [31:0]              rdat;

  // ----------------------------------------
  // 40 MHz tick enable from the 50 MHz clock
  // ----------------------------------------
  // fractional divider: four ticks in every five clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_acc <= 7'h00;
      tick     <= 1'b0;
    end else if (tick_acc + `MPFC_TICK_MHZ >= `MPFC_PCLK_MHZ) begin
      tick_acc <= tick_acc + `MPFC_TICK_MHZ - `MPFC_PCLK_MHZ;
      tick     <= 1'b1;
    end else begin
      tick_acc <= tick_acc + `MPFC_TICK_MHZ;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------
  // unlock key
  // ----------------------------------------
  // exactly one register stage, then compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q    <= '0;
      unlocked <= 1'b0;
    end else begin
      key_q    <= unlock_key;
      unlocked <= (key_q == UNLOCK_KEY);
    end
  end

  // ----------------------------------------
  // angle event decode for the active channel
  // ----------------------------------------
  always_comb begin
    cc      = cfg[cur_ch];
    new_pos = engine_position_bundle.synced && (engine_position_bundle.angle != prev_angle);
    hit_p   = new_pos && engine_position_bundle.angle == cc.start;
    hit_e1  = new_pos && engine_position_bundle.angle ==
              ang_before(cc.start, cc.adv1, engine_position_bundle.cycle_len);
    hit_e2  = new_pos && engine_position_bundle.angle ==
              ang_before(cc.start, cc.adv2, engine_position_bundle.cycle_len);
    hit_sw  = new_pos && engine_position_bundle.angle == cc.sw_angle;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_angle <= '0;
    end else begin
      prev_angle <= engine_position_bundle.angle;
    end
  end

  // ----------------------------------------
  // channel multiplexer
  // ----------------------------------------
  // advance to the next channel and strobe for one clock at the switch angle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ch                <= 2'h0;
      channel_switch_strobe <= 1'b0;
    end else begin
      channel_switch_strobe <= hit_sw;
      if (hit_sw) begin
        cur_ch <= cur_ch + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // early pulses: started by angle, timed in ticks
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_e1 <= '0;
      cnt_e2 <= '0;
    end else if (hit_sw) begin
      cnt_e1 <= '0;
      cnt_e2 <= '0;
    end else begin
      if (hit_e1 && cc.gate && cc.e1_on) begin
        cnt_e1 <= cc.len1;
      end else begin
        cnt_e1 <= len_step(cnt_e1, tick);
      end
      if (hit_e2 && cc.gate && cc.e2_on) begin
        cnt_e2 <= cc.len2;
      end else begin
        cnt_e2 <= len_step(cnt_e2, tick);
      end
    end
  end

  // ----------------------------------------
  // primary and late pulse sequencer
  // ----------------------------------------
  // one step per clock; once through per channel slot, so at most five pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq     <= MPFC_IDLE;
      cnt_p   <= '0;
      cnt_l1  <= '0;
      cnt_l2  <= '0;
      cnt_gap <= '0;
    end else if (hit_sw) begin
      seq     <= MPFC_IDLE;
      cnt_p   <= '0;
      cnt_l1  <= '0;
      cnt_l2  <= '0;
      cnt_gap <= '0;
    end else begin
      cnt_p  <= len_step(cnt_p, tick);
      cnt_l1 <= len_step(cnt_l1, tick);
      cnt_l2 <= len_step(cnt_l2, tick);
      case (seq)
        MPFC_IDLE: begin
          if (hit_p && cc.gate && cc.len3 != '0) begin
            cnt_p <= cc.len3;
            seq   <= MPFC_PRIM;
          end
        end
        MPFC_PRIM: begin
          if (tick && cnt_p == 18'h00001) begin
            cnt_gap <= cc.gap1;
            seq     <= cc.l1_on ? MPFC_GAP1 : MPFC_DONE;
          end
        end
        MPFC_GAP1: begin
          if (cnt_gap == '0) begin
            cnt_l1 <= cc.lenp;
            seq    <= (cc.lenp == '0) ? MPFC_DONE : MPFC_LATE1;
          end else if (tick) begin
            cnt_gap <= cnt_gap - 1'b1;
          end
        end
        MPFC_LATE1: begin
          if (tick && cnt_l1 == 18'h00001) begin
            cnt_gap <= cc.gap2;
            seq     <= (cc.l2_on && cc.l1_on) ? MPFC_GAP2 : MPFC_DONE;
          end
        end
        MPFC_GAP2: begin
          if (cnt_gap == '0) begin
            cnt_l2 <= cc.len4;
            seq    <= (cc.len4 == '0) ? MPFC_DONE : MPFC_LATE2;
          end else if (tick) begin
            cnt_gap <= cnt_gap - 1'b1;
          end
        end
        MPFC_LATE2: begin
          if (tick && cnt_l2 == 18'h00001) begin
            seq <= MPFC_DONE;
          end
        end
        MPFC_DONE: begin
          seq <= MPFC_DONE;
        end
        default: begin
          seq <= MPFC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign any_pulse = (cnt_e1 != '0) || (cnt_e2 != '0) || (cnt_p != '0) ||
                     (cnt_l1 != '0) || (cnt_l2 != '0);

  // route the combined train to the active channel, low while locked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_train_ch1 <= 1'b0;
      pulse_train_ch2 <= 1'b0;
      pulse_train_ch3 <= 1'b0;
      pulse_train_ch4 <= 1'b0;
    end else begin
      pulse_train_ch1 <= unlocked && any_pulse && cur_ch == 2'h0;
      pulse_train_ch2 <= unlocked && any_pulse && cur_ch == 2'h1;
      pulse_train_ch3 <= unlocked && any_pulse && cur_ch == 2'h2;
      pulse_train_ch4 <= unlocked && any_pulse && cur_ch == 2'h3;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign rch     = paddr[7:6];
  assign roff    = paddr[5:0];
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_en   = psel && penable && !pready;
  assign rmapped = (paddr == `MPFC_OFF_STATUS) ||
                   (paddr[11:8] == 4'h0 && roff <= `MPFC_OFF_SWITCH && paddr[1:0] == 2'h0);

  // read mux
  always_comb begin
    rdat = 32'h0000_0000;
    if (paddr == `MPFC_OFF_STATUS) begin
      rdat = {21'h0, seq, unlocked, 1'b0, cur_ch};
    end else begin
      case (roff)
        `MPFC_OFF_CTRL:   rdat = {27'h0, cfg[rch].l2_on, cfg[rch].l1_on, cfg[rch].e2_on,
                                  cfg[rch].e1_on, cfg[rch].gate};
        `MPFC_OFF_START:  rdat = {16'h0, cfg[rch].start};
        `MPFC_OFF_ADV1:   rdat = {16'h0, cfg[rch].adv1};
        `MPFC_OFF_ADV2:   rdat = {16'h0, cfg[rch].adv2};
        `MPFC_OFF_LEN1:   rdat = {14'h0, cfg[rch].len1};
        `MPFC_OFF_LEN2:   rdat = {14'h0, cfg[rch].len2};
        `MPFC_OFF_LENP:   rdat = {14'h0, cfg[rch].len3};
        `MPFC_OFF_GAP1:   rdat = {8'h0, cfg[rch].gap1};
        `MPFC_OFF_LEN3:   rdat = {14'h0, cfg[rch].lenp};
        `MPFC_OFF_GAP2:   rdat = {8'h0, cfg[rch].gap2};
        `MPFC_OFF_LEN4:   rdat = {14'h0, cfg[rch].len4};
        `MPFC_OFF_SWITCH: rdat = {16'h0, cfg[rch].sw_angle};
        default:          rdat = 32'h0000_0000;
      endcase
    end
  end

  // one wait state, registered answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_en;
      prdata  <= rd_en ? (rmapped ? rdat : 32'h0000_0000) : prdata;
      pslverr <= rd_en && !rmapped;
    end
  end

  // register writes; wide values keep only their low bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        cfg[i] <= '0;
      end
    end else if (wr_en && rmapped && paddr[11:8] == 4'h0) begin
      case (roff)
        `MPFC_OFF_CTRL: begin
          cfg[rch].gate  <= pwdata[`MPFC_BIT_GATE];
          cfg[rch].e1_on <= pwdata[`MPFC_BIT_E1];
          cfg[rch].e2_on <= pwdata[`MPFC_BIT_E2];
          cfg[rch].l1_on <= pwdata[`MPFC_BIT_L1];
          cfg[rch].l2_on <= pwdata[`MPFC_BIT_L2];
        end
        `MPFC_OFF_START:  cfg[rch].start    <= pwdata[`MPFC_ANG_W-1:0];
        `MPFC_OFF_ADV1:   cfg[rch].adv1     <= pwdata[`MPFC_ANG_W-1:0];
        `MPFC_OFF_ADV2:   cfg[rch].adv2     <= pwdata[`MPFC_ANG_W-1:0];
        `MPFC_OFF_LEN1:   cfg[rch].len1     <= pwdata[`MPFC_LEN_W-1:0];
        `MPFC_OFF_LEN2:   cfg[rch].len2     <= pwdata[`MPFC_LEN_W-1:0];
        `MPFC_OFF_LENP:   cfg[rch].len3     <= pwdata[`MPFC_LEN_W-1:0];
        `MPFC_OFF_GAP1:   cfg[rch].gap1     <= pwdata[`MPFC_GAP_W-1:0];
        `MPFC_OFF_LEN3:   cfg[rch].lenp     <= pwdata[`MPFC_LEN_W-1:0];
        `MPFC_OFF_GAP2:   cfg[rch].gap2     <= pwdata[`MPFC_GAP_W-1:0];
        `MPFC_OFF_LEN4:   cfg[rch].len4     <= pwdata[`MPFC_LEN_W-1:0];
        `MPFC_OFF_SWITCH: cfg[rch].sw_angle <= pwdata[`MPFC_ANG_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_one_clk_a: assert property (channel_switch_strobe |=> !channel_switch_strobe)
    else $error("switch strobe longer than one clock");
  strobe_cause_a: assert property (hit_sw |=> channel_switch_strobe && cur_ch == $past(cur_ch) + 2'h1)
    else $error("channel did not advance with strobe");
  locked_low_a: assert property (!$past(unlocked) |-> !(pulse_train_ch1 || pulse_train_ch2 ||
                                 pulse_train_ch3 || pulse_train_ch4))
    else $error("output active while locked");
  key_stage_a: assert property ($past(key_q) == UNLOCK_KEY |-> unlocked)
    else $error("valid key did not unlock");
  gate_blocks_a: assert property (hit_p && !cc.gate && seq == MPFC_IDLE && !hit_sw |=> seq == MPFC_IDLE)
    else $error("primary started with gate off");
  prim_start_a: assert property (hit_p && cc.gate && cc.len3 != '0 && seq == MPFC_IDLE && !hit_sw
                                 |=> seq == MPFC_PRIM && cnt_p == $past(cc.len3))
    else $error("primary did not start at start angle");
  e1_enable_a: assert property (hit_e1 && !cc.e1_on && !hit_sw && cnt_e1 == '0 |=> cnt_e1 == '0)
    else $error("first early pulse without enable");
  e2_enable_a: assert property (hit_e2 && !cc.e2_on && !hit_sw && cnt_e2 == '0 |=> cnt_e2 == '0)
    else $error("second early pulse without enable");
  late1_off_a: assert property (seq == MPFC_PRIM && !cc.l1_on && tick && cnt_p == 18'h00001 && !hit_sw
                                |=> seq == MPFC_DONE)
    else $error("first late pulse without enable");
  late2_dep_a: assert property (seq == MPFC_GAP2 |-> $past(cc.l1_on))
    else $error("second late pulse without first late enable");
  out_onehot_a: assert property ($onehot0({pulse_train_ch1, pulse_train_ch2,
                                 pulse_train_ch3, pulse_train_ch4}))
    else $error("more than one channel driven");
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

  prim_seen_c:   cover property (seq == MPFC_PRIM ##1 seq == MPFC_GAP1);
  late2_seen_c:  cover property (seq == MPFC_LATE2);
  switch_seen_c: cover property (channel_switch_strobe && cur_ch == 2'h0);
  out_seen_c:    cover property (pulse_train_ch4);

endmodule
